// [oag_core.sv]
`default_nettype none
`include "oag_defs.svh"
module oag_core (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire oag_pkg::oag_mode_t mode_i,
  input wire logic mem_op_i,
  input wire logic mask_raise_op_i,
  input wire logic mask_clear_op_i,
  input wire logic [7:0] prefix_i,
  input wire logic [7:0] x_i,
  input wire logic [7:0] y_i,
  input wire logic [7:0] rd_data_i,
  output logic [15:0] rd_addr_o,
  output logic rd_en_o,
  output logic busy_o,
  output logic done_o,
  output logic mode_err_o,
  output logic [1:0] ext_len_o,
  output oag_pkg::oag_result_t result_o
);
  typedef enum logic [2:0] {S_IDLE, S_B1, S_B2, S_P1, S_P2, S_DONE} oag_st_t;
  oag_st_t st_q, st_d;
  logic [15:0] pc_q, pc_d, ra_q, ra_d;
  logic [7:0] b1_q, b1_d, b2_q, b2_d, p1_q, p1_d, ix_q, ix_d;
  logic busy_q, busy_d, rden_q, rden_d, done_q, done_d, err_q, err_d;
  logic [1:0] len_q, len_d;
  oag_pkg::oag_mode_t m_q, m_d;
  oag_pkg::oag_result_t res_q, res_d;
  logic [15:0] op_word, ptr_word;
  logic [7:0] ptr_next;
  logic use_y;

  oag_word_asm u_op (.lo_addr_byte_i(b1_q), .hi_addr_byte_i(b2_q),
    .wide_i(m_q == oag_pkg::OAG_DIR_L || m_q == oag_pkg::OAG_IDX_L), .word_o(op_word));
  oag_word_asm u_ptr (.lo_addr_byte_i(p1_q), .hi_addr_byte_i(rd_data_i),
    .wide_i(1'b1), .word_o(ptr_word));

  assign ptr_next = b1_q + 8'h01;

  // effective mode after prefix
  function automatic oag_pkg::oag_mode_t pfx_mode(input oag_pkg::oag_mode_t m,
                                                   input logic [7:0] p);
    pfx_mode = m;
    if (p == `OAG_PFX_IND) begin
      case (m)
        oag_pkg::OAG_DIR_S: pfx_mode = oag_pkg::OAG_IND_S;
        oag_pkg::OAG_DIR_L: pfx_mode = oag_pkg::OAG_IND_L;
        oag_pkg::OAG_IDX_S: pfx_mode = oag_pkg::OAG_IIX_S;
        oag_pkg::OAG_IDX_L: pfx_mode = oag_pkg::OAG_IIX_L;
        oag_pkg::OAG_REL_D: pfx_mode = oag_pkg::OAG_REL_I;
        oag_pkg::OAG_BIT_D: pfx_mode = oag_pkg::OAG_BIT_I;
        oag_pkg::OAG_BTR_D: pfx_mode = oag_pkg::OAG_BTR_I;
        default: pfx_mode = m;
      endcase
    end
  endfunction

  // bytes after the opcode
  function automatic logic [1:0] ext_len(input oag_pkg::oag_mode_t m);
    case (m)
      oag_pkg::OAG_INH, oag_pkg::OAG_IDX_0: ext_len = 2'd0;
      oag_pkg::OAG_DIR_L, oag_pkg::OAG_IDX_L, oag_pkg::OAG_BTR_D: ext_len = 2'd2;
      oag_pkg::OAG_BTR_I: ext_len = 2'd2;
      default: ext_len = 2'd1;
    endcase
  endfunction

  always_comb begin
    use_y = 1'b0;
    if (prefix_i == `OAG_PFX_Y) begin
      use_y = (mode_i == oag_pkg::OAG_INH || mode_i == oag_pkg::OAG_IMM ||
               mode_i == oag_pkg::OAG_DIR_S || mode_i == oag_pkg::OAG_DIR_L ||
               mode_i == oag_pkg::OAG_IDX_0 || mode_i == oag_pkg::OAG_IDX_S ||
               mode_i == oag_pkg::OAG_IDX_L);
    end else if (prefix_i == `OAG_PFX_YIND) begin
      use_y = (mode_i == oag_pkg::OAG_IDX_S || mode_i == oag_pkg::OAG_IDX_L);
    end
  end

  always_comb begin
    st_d = st_q;
    pc_d = pc_q;
    ra_d = ra_q;
    b1_d = b1_q;
    b2_d = b2_q;
    p1_d = p1_q;
    ix_d = ix_q;
    len_d = len_q;
    m_d = m_q;
    res_d = res_q;
    rden_d = 1'b0;
    done_d = 1'b0;
    err_d = err_q;
    case (st_q)
      S_IDLE: begin
        if (start_i) begin
          m_d = pfx_mode(mode_i, prefix_i);
          if (prefix_i == `OAG_PFX_YIND) begin
            m_d = pfx_mode(mode_i, `OAG_PFX_IND);
          end
          len_d = ext_len(m_d);
          ix_d = use_y ? y_i : x_i;
          res_d = '0;
          res_d.use_y = use_y;
          res_d.mask_we = mask_raise_op_i | mask_clear_op_i;
          res_d.mask = mask_raise_op_i ? `OAG_MASK_HI : `OAG_MASK_LO;
          err_d = mem_op_i && (m_d == oag_pkg::OAG_DIR_L || m_d == oag_pkg::OAG_IDX_L ||
                  m_d == oag_pkg::OAG_IMM);
          pc_d = ra_q;
          b1_d = `OAG_BYTE_RST;
          b2_d = `OAG_BYTE_RST;
          if (ext_len(m_d) == 2'd0) begin
            st_d = S_DONE;
          end else begin
            st_d = S_B1;
            rden_d = 1'b1;
          end
        end
      end
      S_B1: begin
        b1_d = rd_data_i;
        pc_d = pc_q + 16'h0001;
        if (len_q == 2'd2 && m_q != oag_pkg::OAG_BTR_I) begin
          st_d = S_B2;
          rden_d = 1'b1;
        end else if (m_q == oag_pkg::OAG_IND_S || m_q == oag_pkg::OAG_IND_L ||
                     m_q == oag_pkg::OAG_IIX_S || m_q == oag_pkg::OAG_IIX_L ||
                     m_q == oag_pkg::OAG_REL_I || m_q == oag_pkg::OAG_BIT_I ||
                     m_q == oag_pkg::OAG_BTR_I) begin
          st_d = S_P1;
          rden_d = 1'b1;
        end else begin
          st_d = S_DONE;
        end
      end
      S_B2: begin
        b2_d = rd_data_i;
        pc_d = pc_q + 16'h0001;
        st_d = S_DONE;
      end
      S_P1: begin
        p1_d = rd_data_i;
        if (m_q == oag_pkg::OAG_IND_L || m_q == oag_pkg::OAG_IIX_L) begin
          st_d = S_P2;
          rden_d = 1'b1;
        end else begin
          st_d = S_DONE;
        end
      end
      S_P2: begin
        b2_d = ptr_word[7:0];
        b1_d = ptr_word[15:8];
        st_d = S_DONE;
      end
      default: begin
        st_d = S_IDLE;
        done_d = 1'b1;
        case (m_q)
          oag_pkg::OAG_IMM: begin
            res_d.is_imm = 1'b1;
            res_d.imm = b1_q;
          end
          oag_pkg::OAG_DIR_S, oag_pkg::OAG_BIT_D, oag_pkg::OAG_BTR_D:
            res_d.addr = {`OAG_PAGE0_HI, b1_q};
          oag_pkg::OAG_DIR_L: res_d.addr = op_word;
          oag_pkg::OAG_IDX_0: res_d.addr = {`OAG_PAGE0_HI, ix_q};
          oag_pkg::OAG_IDX_S: res_d.addr = {`OAG_PAGE0_HI, b1_q} + {8'h00, ix_q};
          oag_pkg::OAG_IDX_L: res_d.addr = op_word + {8'h00, ix_q};
          oag_pkg::OAG_IND_S, oag_pkg::OAG_REL_I, oag_pkg::OAG_BIT_I, oag_pkg::OAG_BTR_I:
            res_d.addr = {`OAG_PAGE0_HI, p1_q};
          oag_pkg::OAG_IND_L: res_d.addr = {b1_q, b2_q};
          oag_pkg::OAG_IIX_S: res_d.addr = {`OAG_PAGE0_HI, p1_q} + {8'h00, ix_q};
          oag_pkg::OAG_IIX_L: res_d.addr = {b1_q, b2_q} + {8'h00, ix_q};
          default: res_d.addr = `OAG_ADDR_RST;
        endcase
      end
    endcase
    // fetch address for next read
    if (rden_d) begin
      if (st_d == S_B1 || st_d == S_B2) begin
        ra_d = (st_d == S_B1) ? pc_d : pc_q + 16'h0001;
      end else if (st_d == S_P1) begin
        ra_d = {`OAG_PAGE0_HI, rd_data_i};
      end else begin
        ra_d = {`OAG_PAGE0_HI, ptr_next};
      end
    end
    busy_d = (st_d != S_IDLE);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      pc_q <= `OAG_ADDR_RST;
      ra_q <= `OAG_ADDR_RST;
      b1_q <= `OAG_BYTE_RST;
      b2_q <= `OAG_BYTE_RST;
      p1_q <= `OAG_BYTE_RST;
      ix_q <= `OAG_BYTE_RST;
      busy_q <= 1'b0;
      len_q <= 2'd0;
      m_q <= oag_pkg::OAG_INH;
      res_q <= '0;
      rden_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pc_q <= pc_d;
      ra_q <= ra_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      p1_q <= p1_d;
      ix_q <= ix_d;
      busy_q <= busy_d;
      len_q <= len_d;
      m_q <= m_d;
      res_q <= res_d;
      rden_q <= rden_d;
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  assign rd_addr_o = ra_q;
  assign rd_en_o = rden_q;
  assign done_o = done_q;
  assign busy_o = busy_q;
  assign mode_err_o = err_q;
  assign ext_len_o = len_q;
  assign result_o = res_q;

  a_short_idx_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    done_o && m_q == oag_pkg::OAG_IDX_S |-> result_o.addr <= 16'h01fe)
    else $error("short indexed address beyond 1FE");
  a_inh_no_fetch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    start_i && st_q == S_IDLE && mode_i == oag_pkg::OAG_INH && prefix_i != `OAG_PFX_IND
    |=> !rd_en_o ##1 done_o)
    else $error("inherent fetched a byte");
  a_mask_raise: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    start_i && st_q == S_IDLE && mask_raise_op_i |=> result_o.mask == 2'h3)
    else $error("mask raise not level 3");
  a_page0_ptr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_q == S_P1 || st_q == S_P2 |-> rd_addr_o[15:8] == 8'h00)
    else $error("pointer fetch left page zero");
  a_y_prefix: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    start_i && st_q == S_IDLE && prefix_i == 8'h90 && mode_i == oag_pkg::OAG_IDX_0
    |=> ##1 done_o && result_o.addr == {8'h00, $past(y_i, 2)})
    else $error("y prefix not applied");
  a_done_bound: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_q == S_B1 |-> ##[1:4] done_o)
    else $error("address not formed in time");
  a_short_dir: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    done_o && m_q == oag_pkg::OAG_DIR_S |-> result_o.addr[15:8] == 8'h00)
    else $error("short direct left page zero");
  a_mem_op_err: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    start_i && st_q == S_IDLE && mem_op_i && mode_i == oag_pkg::OAG_DIR_L
    && prefix_i == 8'h00 |=> mode_err_o)
    else $error("long form allowed for memory op");
endmodule
`default_nettype wire

// [oag_defs.svh]
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH
`define OAG_PFX_Y 8'h90
`define OAG_PFX_YIND 8'h91
`define OAG_PFX_IND 8'h92
`define OAG_MASK_HI 2'h3
`define OAG_MASK_LO 2'h0
`define OAG_PAGE0_HI 8'h00
`define OAG_ADDR_RST 16'h0000
`define OAG_BYTE_RST 8'h00
`endif

// [oag_pkg.sv]
`default_nettype none
package oag_pkg;
  // the 17 addressing variants in 9 families
  typedef enum logic [4:0] {
    OAG_INH, OAG_IMM, OAG_DIR_S, OAG_DIR_L, OAG_IDX_0, OAG_IDX_S, OAG_IDX_L,
    OAG_IND_S, OAG_IND_L, OAG_IIX_S, OAG_IIX_L, OAG_REL_D, OAG_REL_I,
    OAG_BIT_D, OAG_BIT_I, OAG_BTR_D, OAG_BTR_I
  } oag_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] imm;
    logic is_imm;
    logic use_y;
    logic [1:0] mask;
    logic mask_we;
  } oag_result_t;
endpackage
`default_nettype wire

// [oag_word_asm.sv]
`default_nettype none
`include "oag_defs.svh"
module oag_word_asm (
  input wire logic [7:0] lo_addr_byte_i,
  input wire logic [7:0] hi_addr_byte_i,
  input wire logic wide_i,
  output logic [15:0] word_o
);
  // higher byte from lower memory address
  always_comb begin
    if (wide_i) begin
      word_o = {lo_addr_byte_i, hi_addr_byte_i};
    end else begin
      word_o = {`OAG_PAGE0_HI, lo_addr_byte_i};
    end
  end
endmodule
`default_nettype wire

// [oag_mem_model.sv]
`default_nettype none
module oag_mem_model (
  input wire logic clk_sys_i,
  input wire logic rd_en_i,
  input wire logic [15:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] log_q [$];
  function automatic logic [7:0] byte_at(input logic [15:0] ad);
    return {ad[3:0], ad[7:4]} ^ ad[15:8] ^ 8'h3c;
  endfunction
  // data stands in the cycle of the request; idle bus shows the inverse
  always_comb begin
    rd_data_o = byte_at(rd_addr_i);
    if (rd_en_i !== 1'b1) begin
      rd_data_o = ~rd_data_o;
    end
  end
  always @(posedge clk_sys_i) begin
    if (rd_en_i === 1'b1) begin
      log_q.push_back(rd_addr_i);
    end
  end
endmodule
`default_nettype wire

// [tb_cpu_operand_address_generator.sv]
`default_nettype none
module tb_cpu_operand_address_generator;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  oag_pkg::oag_mode_t mode_i = oag_pkg::OAG_INH;
  logic mem_op_i = 1'b0;
  logic mask_raise_op_i = 1'b0;
  logic mask_clear_op_i = 1'b0;
  logic [7:0] prefix_i = 8'h00;
  logic [7:0] x_i = 8'hff;
  logic [7:0] y_i = 8'hc3;
  logic [7:0] rd_data_i;
  logic [15:0] rd_addr_o;
  logic rd_en_o;
  logic busy_o;
  logic done_o;
  logic mode_err_o;
  logic [1:0] ext_len_o;
  oag_pkg::oag_result_t result_o;
  int fails = 0;
  int n_compared = 0;
  int lat;
  logic [15:0] p;
  logic [15:0] a;
  always #5 clk_sys_i = ~clk_sys_i;
  oag_core i_dut (.clk_sys_i, .rst_i, .start_i, .mode_i, .mem_op_i, .mask_raise_op_i,
    .mask_clear_op_i, .prefix_i, .x_i, .y_i, .rd_data_i, .rd_addr_o, .rd_en_o, .busy_o,
    .done_o, .mode_err_o, .ext_len_o, .result_o);
  oag_mem_model i_mem (.clk_sys_i, .rd_en_i(rd_en_o), .rd_addr_i(rd_addr_o),
    .rd_data_o(rd_data_i));

  function automatic logic [7:0] m(input logic [15:0] ad);
    return i_mem.byte_at(ad);
  endfunction
  // page-zero word pointer, second byte stays in page zero
  function automatic logic [15:0] w0(input logic [7:0] ad);
    return {m({8'h00, ad}), m({8'h00, ad + 8'h01})};
  endfunction

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic run_op(input oag_pkg::oag_mode_t md, input logic [7:0] pfx,
      input logic [2:0] flags, input int hold);
    int k;
    i_mem.log_q.delete();
    mode_i = md;
    prefix_i = pfx;
    {mem_op_i, mask_raise_op_i, mask_clear_op_i} = flags;
    start_i = 1'b1;
    for (k = 0; k < hold; k++) begin
      tick();
      mode_i = oag_pkg::OAG_INH;
      prefix_i = 8'h00;
      if (k == 0) begin
        check("busy", 16'(busy_o), 16'h0001);
      end
    end
    start_i = 1'b0;
    lat = hold;
    while (done_o !== 1'b1 && lat < 12) begin
      tick();
      lat++;
    end
    if (done_o !== 1'b1) begin
      fails++;
      print_verdict();
    end
    check("idle", 16'(busy_o), 16'h0000);
    p = (i_mem.log_q.size() > 0) ? i_mem.log_q[0] : 16'h0000;
    a = {8'h00, m(p)};
  endtask

  task automatic chk_len(input string what, input logic [1:0] n, input int r);
    check({what, " ext"}, 16'(ext_len_o), 16'(n));
    check({what, " reads"}, 16'(i_mem.log_q.size()), 16'(r));
  endtask

  task automatic t_inherent();
    run_op(oag_pkg::OAG_INH, 8'h00, 3'b010, 1);
    chk_len("inh", 2'h0, 0);
    check("mask", 16'(result_o.mask), 16'h0003);
    check("mask_we", 16'(result_o.mask_we), 16'h0001);
    run_op(oag_pkg::OAG_INH, 8'h00, 3'b001, 1);
    check("mask", 16'(result_o.mask), 16'h0000);
    $display("test inherent done");
  endtask

  task automatic t_direct();
    int lat_s;
    run_op(oag_pkg::OAG_IMM, 8'h00, 3'b000, 1);
    chk_len("imm", 2'h1, 1);
    check("imm", 16'(result_o.imm), 16'(m(p)));
    check("is_imm", 16'(result_o.is_imm), 16'h0001);
    run_op(oag_pkg::OAG_DIR_S, 8'h00, 3'b000, 1);
    lat_s = lat;
    chk_len("dir_s", 2'h1, 1);
    check("dir_s", result_o.addr, a);
    run_op(oag_pkg::OAG_DIR_L, 8'h00, 3'b000, 1);
    chk_len("dir_l", 2'h2, 2);
    check("dir_l", result_o.addr, {m(p), m(p + 16'h0001)});
    check("long slower", 16'(lat > lat_s), 16'h0001);
    $display("test direct done");
  endtask

  task automatic t_indexed();
    run_op(oag_pkg::OAG_IDX_0, 8'h00, 3'b000, 1);
    chk_len("idx_0", 2'h0, 0);
    check("idx_0", result_o.addr, 16'h00ff);
    run_op(oag_pkg::OAG_IDX_0, 8'h90, 3'b000, 1);
    chk_len("idx_0 y", 2'h0, 0);
    check("idx_0 y", result_o.addr, 16'h00c3);
    run_op(oag_pkg::OAG_IDX_S, 8'h00, 3'b000, 1);
    chk_len("idx_s", 2'h1, 1);
    check("idx_s", result_o.addr, a + 16'h00ff);
    run_op(oag_pkg::OAG_IDX_L, 8'h90, 3'b000, 1);
    chk_len("idx_l", 2'h2, 2);
    check("idx_l", result_o.addr, {m(p), m(p + 16'h0001)} + 16'h00c3);
    check("use_y", 16'(result_o.use_y), 16'h0001);
    $display("test indexed done");
  endtask

  task automatic t_indirect();
    run_op(oag_pkg::OAG_DIR_S, 8'h92, 3'b000, 1);
    chk_len("ind_s", 2'h1, 2);
    check("ind_s ptr", i_mem.log_q[1], a);
    check("ind_s", result_o.addr, {8'h00, m(a)});
    run_op(oag_pkg::OAG_DIR_L, 8'h92, 3'b000, 1);
    chk_len("ind_l", 2'h1, 3);
    check("ind_l", result_o.addr, w0(a[7:0]));
    run_op(oag_pkg::OAG_IDX_S, 8'h92, 3'b000, 1);
    check("iix_s", result_o.addr, {8'h00, m(a)} + 16'h00ff);
    check("use_y", 16'(result_o.use_y), 16'h0000);
    run_op(oag_pkg::OAG_IDX_L, 8'h91, 3'b000, 1);
    check("iix_l", result_o.addr, w0(a[7:0]) + 16'h00c3);
    check("use_y", 16'(result_o.use_y), 16'h0001);
    $display("test indirect done");
  endtask

  task automatic t_bit_rel();
    run_op(oag_pkg::OAG_BIT_D, 8'h00, 3'b000, 1);
    chk_len("bit_d", 2'h1, 1);
    check("bit_d", result_o.addr, a);
    run_op(oag_pkg::OAG_BTR_D, 8'h00, 3'b000, 1);
    chk_len("btr_d", 2'h2, 2);
    check("btr_d", result_o.addr, a);
    run_op(oag_pkg::OAG_REL_D, 8'h00, 3'b000, 1);
    chk_len("rel_d", 2'h1, 1);
    run_op(oag_pkg::OAG_REL_D, 8'h92, 3'b000, 1);
    chk_len("rel_i", 2'h1, 2);
    check("rel_i", result_o.addr, {8'h00, m(a)});
    run_op(oag_pkg::OAG_BIT_D, 8'h92, 3'b000, 1);
    chk_len("bit_i", 2'h1, 2);
    check("bit_i", result_o.addr, {8'h00, m(a)});
    run_op(oag_pkg::OAG_BTR_D, 8'h92, 3'b000, 1);
    chk_len("btr_i", 2'h2, 2);
    check("btr_i", result_o.addr, {8'h00, m(a)});
    $display("test bit relative done");
  endtask

  task automatic t_mem_op();
    run_op(oag_pkg::OAG_DIR_L, 8'h00, 3'b100, 1);
    check("err dir_l", 16'(mode_err_o), 16'h0001);
    run_op(oag_pkg::OAG_IMM, 8'h00, 3'b100, 1);
    check("err imm", 16'(mode_err_o), 16'h0001);
    run_op(oag_pkg::OAG_DIR_S, 8'h00, 3'b100, 1);
    check("err dir_s", 16'(mode_err_o), 16'h0000);
    $display("test mem op done");
  endtask

  task automatic t_refuse();
    int n;
    n = 0;
    // start held a second edge while busy
    run_op(oag_pkg::OAG_DIR_L, 8'h92, 3'b000, 2);
    check("busy start", result_o.addr, w0(a[7:0]));
    repeat (8) begin
      tick();
      n += (done_o === 1'b1) ? 1 : 0;
    end
    check("extra done", 16'(n), 16'h0000);
    $display("test refuse done");
  endtask

  initial begin
    repeat (6) tick();
    rst_i = 1'b0;
    check("reset done", 16'(done_o), 16'h0000);
    t_inherent();
    t_direct();
    t_indexed();
    t_indirect();
    t_bit_rel();
    t_mem_op();
    t_refuse();
    print_verdict();
  end
endmodule
`default_nettype wire
